// >>> design/scset_bank.sv
// Module: scope settings bit-field bank with decoded control outputs
`timescale 1ns/10ps
// Notes on behaviour
// - Analog bit 6 math on, bit 7 subtract
// - Analog bits 0,4,5: on, invert, average
// - Logic bit 1 pull enable, bit 2 up
// - Logic bit 3 draws low levels thick
// - Logic bits 5-7: serial, parallel, ASCII decode
// - Trigger bits 5-7 modes; none means both edges
// - Display bits 1:0 pick the grid style
// - Display bit 6 lines, else pixels
// - Spectrum bits 5-7 views; none means meter
// - Sweep bits 4-7 enable parameter sweeps
// - Sweep bits 0-3 acceleration, direction, ping-pong
// - Sniffer bits 2:0 pick UART baud rate
// - Sniffer bits 3,4 SPI polarity and phase
// - Sniffer bit 5 parity check, 6 odd
// - Sniffer bit 7 selects two stop bits
// - Status bit 0 abandons trigger wait
// - Status bits 1,2 reload generator, acquisition
// - Status bit 3 sniffing; 4,5 stopped, triggered
// - Status bits 6,7 meter; none means frequency
// - Low-index writes flag acquisition, high flag generator
module scset_bank (
  input wire logic CLK,
  input wire logic ARST_N,
  // Settings write port from the command decoder
  input wire logic WR_EN,
  input wire logic [5:0] WR_INDEX,
  input wire logic [7:0] WR_DATA,
  // Settings read port
  input wire logic [5:0] RD_INDEX,
  output logic [7:0] RD_DATA,
  // Events from acquisition and generator logic
  input wire logic GEN_RELOAD_DONE,
  input wire logic ACQ_RELOAD_DONE,
  input wire logic TRIG_ABORT_DONE,
  input wire logic SCOPE_STOPPED,
  input wire logic SCOPE_TRIGGERED,
  // Analog channels, bit 0 is channel one
  output logic [1:0] ANA_ON,
  output logic [1:0] ANA_INVERT,
  output logic [1:0] ANA_AVERAGE,
  output logic [1:0] ANA_MATH_ON,
  output logic [1:0] ANA_MATH_SUB,
  // Logic inputs
  output logic LOGIC_ON,
  output logic LOGIC_PULL_EN,
  output logic LOGIC_PULL_UP,
  output logic LOGIC_LOW_THICK,
  output logic LOGIC_INVERT,
  output logic LOGIC_SERIAL_DEC,
  output logic LOGIC_PARALLEL_DEC,
  output logic LOGIC_ASCII_VIEW,
  // Trigger
  output logic TRIG_NORMAL,
  output logic TRIG_SINGLE,
  output logic TRIG_AUTO,
  output logic TRIG_SLOPE,
  output logic TRIG_WINDOW,
  output logic TRIG_EDGE,
  output logic TRIG_DUAL_EDGE,
  // Cursors
  output logic CURSOR_H_CH1,
  output logic CURSOR_H_CH2,
  // Display
  output logic [1:0] GRID_STYLE,
  output logic DRAW_LINES,
  // Spectrum and views
  output logic [1:0] FFT_WINDOW,
  output logic VIEW_SCOPE,
  output logic VIEW_XY,
  output logic VIEW_FFT,
  output logic VIEW_METER,
  // Generator sweep: frequency, amplitude, offset, duty
  output logic [3:0] SWEEP_ENABLE,
  output logic SWEEP_ACCEL_DIR,
  output logic SWEEP_ACCEL,
  output logic SWEEP_DIR,
  output logic SWEEP_PING_PONG,
  // Sniffer
  output logic [15:0] UART_BAUD_DIV,
  output logic SPI_CPOL,
  output logic SNIFF_CLOCK_PHASE,
  output logic UART_PARITY_EN,
  output logic UART_PARITY_ODD,
  output logic UART_TWO_STOP,
  // Status actions
  output logic ABORT_TRIG_WAIT,
  output logic RELOAD_GEN,
  output logic RELOAD_ACQ,
  output logic SNIFF_MODE,
  output logic METER_VDC,
  output logic METER_VPP,
  output logic METER_FREQ
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  localparam int NUM_RW = 10; // Plain read/write bytes, indices 1..10

  logic [7:0] setting [1:NUM_RW]; // Read/write bit-field bytes
  logic [7:0] status; // Status byte, host and device bits
  logic [7:0] ch1; // Aliases of stored bytes
  logic [7:0] ch2;
  logic [7:0] lgc;
  logic [7:0] trg;
  logic [7:0] cur;
  logic [7:0] dsp;
  logic [7:0] spc;
  logic [7:0] swp;
  logic [7:0] snf;
  logic status_wr; // Host write to the status byte
  logic acq_auto; // Write that requests acquisition reload
  logic gen_auto; // Write that requests generator reload

  // Map an index to a baud-rate divisor for the current clock
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int rate;
    rate = scset_pkg::BAUD_0;
    unique case (sel)
      3'h0: rate = scset_pkg::BAUD_0;
      3'h1: rate = scset_pkg::BAUD_1;
      3'h2: rate = scset_pkg::BAUD_2;
      3'h3: rate = scset_pkg::BAUD_3;
      3'h4: rate = scset_pkg::BAUD_4;
      3'h5: rate = scset_pkg::BAUD_5;
      3'h6: rate = scset_pkg::BAUD_6;
      3'h7: rate = scset_pkg::BAUD_7;
    endcase
    return 16'(scset_pkg::CLK_HZ / rate);
  endfunction : baud_div

  assign ch1 = setting[scset_pkg::IDX_CH1];
  assign ch2 = setting[scset_pkg::IDX_CH2];
  assign lgc = setting[scset_pkg::IDX_LOGIC];
  assign trg = setting[scset_pkg::IDX_TRIG];
  assign cur = setting[scset_pkg::IDX_CURSOR];
  assign dsp = setting[scset_pkg::IDX_DISPLAY];
  assign spc = setting[scset_pkg::IDX_SPECTRUM];
  assign swp = setting[scset_pkg::IDX_SWEEP];
  assign snf = setting[scset_pkg::IDX_SNIFF];

  // ----------------------------------------------------------------
  // Host writes
  // ----------------------------------------------------------------
  // Writes below IDX_ACQ_LIMIT, or above IDX_GEN_LIMIT up to IDX_LAST, feed the automatic update flags
  assign status_wr = WR_EN && (WR_INDEX == scset_pkg::IDX_STATUS);
  assign acq_auto = WR_EN && (WR_INDEX < scset_pkg::IDX_ACQ_LIMIT);
  assign gen_auto = WR_EN && (WR_INDEX > scset_pkg::IDX_GEN_LIMIT)
                    && (WR_INDEX <= scset_pkg::IDX_LAST);

  // One storage process per read/write byte
  genvar gi;
  generate
    for (gi = 1; gi <= NUM_RW; gi++) begin : g_rw
      // Byte takes host data when its index is written
      always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          setting[gi] <= scset_pkg::RST_SETTING;
        end else if (WR_EN && (WR_INDEX == 6'(gi))) begin
          setting[gi] <= WR_DATA;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  // Host bits follow writes, except bit 2, which any status write sets; done pulses clear, a set wins a clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= scset_pkg::RST_STATUS;
    end else begin
      // Trigger-wait abort flag
      if (status_wr) begin
        status[0] <= WR_DATA[0];
      end else if (TRIG_ABORT_DONE) begin
        status[0] <= 1'b0;
      end
      // Generator reload flag
      if (gen_auto || (status_wr && WR_DATA[1])) begin
        status[1] <= 1'b1;
      end else if (status_wr) begin
        status[1] <= 1'b0;
      end else if (GEN_RELOAD_DONE) begin
        status[1] <= 1'b0;
      end
      // Acquisition reload flag; status index itself is below limit
      if (acq_auto && (!status_wr || WR_DATA[2])) begin
        status[2] <= 1'b1;
      end else if (status_wr) begin
        status[2] <= 1'b1;
      end else if (ACQ_RELOAD_DONE) begin
        status[2] <= 1'b0;
      end
      // Sniffer mode and meter selection are host levels
      if (status_wr) begin
        status[3] <= WR_DATA[3];
        status[7:6] <= WR_DATA[7:6];
      end
      // Device-reported state, never host-written
      status[scset_pkg::BIT_STOPPED] <= SCOPE_STOPPED;
      status[scset_pkg::BIT_TRIGGERED] <= SCOPE_TRIGGERED;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Registered read; indices outside this bank read as zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RD_DATA <= 8'h00;
    end else if (RD_INDEX == scset_pkg::IDX_STATUS) begin
      RD_DATA <= status;
    end else if ((RD_INDEX >= 6'h01) && (RD_INDEX <= 6'(NUM_RW))) begin
      RD_DATA <= setting[RD_INDEX];
    end else begin
      RD_DATA <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Analog channel decode
  // ----------------------------------------------------------------
  // Per-channel controls, registered
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ANA_ON <= 2'h0;
      ANA_INVERT <= 2'h0;
      ANA_AVERAGE <= 2'h0;
      ANA_MATH_ON <= 2'h0;
      ANA_MATH_SUB <= 2'h0;
    end else begin
      ANA_ON <= {ch2[scset_pkg::BIT_ON], ch1[scset_pkg::BIT_ON]};
      ANA_INVERT <= {ch2[scset_pkg::BIT_INVERT],
                     ch1[scset_pkg::BIT_INVERT]};
      ANA_AVERAGE <= {ch2[5], ch1[5]};
      ANA_MATH_ON <= {ch2[6], ch1[6]};
      ANA_MATH_SUB <= {ch2[7], ch1[7]};
    end
  end

  // ----------------------------------------------------------------
  // Logic input decode
  // ----------------------------------------------------------------
  // Pull, trace and decoder controls
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LOGIC_ON <= 1'b0;
      LOGIC_PULL_EN <= 1'b0;
      LOGIC_PULL_UP <= 1'b0;
      LOGIC_LOW_THICK <= 1'b0;
      LOGIC_INVERT <= 1'b0;
      LOGIC_SERIAL_DEC <= 1'b0;
      LOGIC_PARALLEL_DEC <= 1'b0;
      LOGIC_ASCII_VIEW <= 1'b0;
    end else begin
      LOGIC_ON <= lgc[scset_pkg::BIT_ON];
      LOGIC_PULL_EN <= lgc[1];
      LOGIC_PULL_UP <= lgc[2];
      LOGIC_LOW_THICK <= lgc[3];
      LOGIC_INVERT <= lgc[scset_pkg::BIT_INVERT];
      LOGIC_SERIAL_DEC <= lgc[5];
      LOGIC_PARALLEL_DEC <= lgc[6];
      LOGIC_ASCII_VIEW <= lgc[7];
    end
  end

  // ----------------------------------------------------------------
  // Trigger and cursor decode
  // ----------------------------------------------------------------
  // Trigger modes; single shot is gated here by the normal bit, trg[0]
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TRIG_NORMAL <= 1'b0;
      TRIG_SINGLE <= 1'b0;
      TRIG_AUTO <= 1'b0;
      TRIG_SLOPE <= 1'b0;
      TRIG_WINDOW <= 1'b0;
      TRIG_EDGE <= 1'b0;
      TRIG_DUAL_EDGE <= 1'b0;
      CURSOR_H_CH1 <= 1'b0;
      CURSOR_H_CH2 <= 1'b0;
    end else begin
      TRIG_NORMAL <= trg[0];
      TRIG_SINGLE <= trg[1] & trg[0];
      TRIG_AUTO <= trg[2];
      TRIG_SLOPE <= trg[5];
      TRIG_WINDOW <= trg[6];
      TRIG_EDGE <= trg[7];
      TRIG_DUAL_EDGE <= (trg[7:5] == 3'h0);
      // Horizontal cursors passed straight on, host keeps them exclusive
      CURSOR_H_CH1 <= cur[3];
      CURSOR_H_CH2 <= cur[4];
    end
  end

  // ----------------------------------------------------------------
  // Display and spectrum decode
  // ----------------------------------------------------------------
  // Grid, trace style, window and view selection
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      GRID_STYLE <= scset_pkg::SCSET_GRID_NONE;
      DRAW_LINES <= 1'b0;
      FFT_WINDOW <= scset_pkg::SCSET_WIN_NONE;
      VIEW_SCOPE <= 1'b0;
      VIEW_XY <= 1'b0;
      VIEW_FFT <= 1'b0;
      VIEW_METER <= 1'b1;
    end else begin
      GRID_STYLE <= scset_pkg::scset_grid_t'(dsp[1:0]);
      DRAW_LINES <= dsp[6];
      // Single window bit assumed; lowest set bit wins otherwise
      if (spc[0]) begin
        FFT_WINDOW <= scset_pkg::SCSET_WIN_HAMMING;
      end else if (spc[1]) begin
        FFT_WINDOW <= scset_pkg::SCSET_WIN_HANN;
      end else if (spc[2]) begin
        FFT_WINDOW <= scset_pkg::SCSET_WIN_BLACKMAN;
      end else begin
        FFT_WINDOW <= scset_pkg::SCSET_WIN_NONE;
      end
      VIEW_SCOPE <= spc[5];
      VIEW_XY <= spc[6];
      VIEW_FFT <= spc[7];
      VIEW_METER <= (spc[7:5] == 3'h0);
    end
  end

  // ----------------------------------------------------------------
  // Generator sweep decode
  // ----------------------------------------------------------------
  // Swept parameters and sweep shape
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SWEEP_ENABLE <= 4'h0;
      SWEEP_ACCEL_DIR <= 1'b0;
      SWEEP_ACCEL <= 1'b0;
      SWEEP_DIR <= 1'b0;
      SWEEP_PING_PONG <= 1'b0;
    end else begin
      SWEEP_ENABLE <= swp[7:4];
      SWEEP_ACCEL_DIR <= swp[0];
      SWEEP_ACCEL <= swp[1];
      SWEEP_DIR <= swp[2];
      SWEEP_PING_PONG <= swp[3];
    end
  end

  // ----------------------------------------------------------------
  // Sniffer decode
  // ----------------------------------------------------------------
  // UART timing and framing, SPI clock mode
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      UART_BAUD_DIV <= scset_pkg::RST_BAUD_DIV;
      SPI_CPOL <= 1'b0;
      SNIFF_CLOCK_PHASE <= 1'b0;
      UART_PARITY_EN <= 1'b0;
      UART_PARITY_ODD <= 1'b0;
      UART_TWO_STOP <= 1'b0;
    end else begin
      UART_BAUD_DIV <= baud_div(snf[2:0]);
      SPI_CPOL <= snf[3];
      SNIFF_CLOCK_PHASE <= snf[4];
      UART_PARITY_EN <= snf[5];
      UART_PARITY_ODD <= snf[6];
      UART_TWO_STOP <= snf[7];
    end
  end

  // ----------------------------------------------------------------
  // Status actions
  // ----------------------------------------------------------------
  // Action levels follow the status flags one cycle later
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ABORT_TRIG_WAIT <= 1'b0;
      RELOAD_GEN <= 1'b0;
      RELOAD_ACQ <= 1'b0;
      SNIFF_MODE <= 1'b0;
      METER_VDC <= 1'b0;
      METER_VPP <= 1'b0;
      METER_FREQ <= 1'b1;
    end else begin
      ABORT_TRIG_WAIT <= status[0];
      RELOAD_GEN <= status[1];
      RELOAD_ACQ <= status[2];
      SNIFF_MODE <= status[3];
      METER_VDC <= status[6];
      METER_VPP <= status[7];
      METER_FREQ <= (status[7:6] == 2'h0);
    end
  end

endmodule : scset_bank

// >>> design/scset_pkg.sv
// Package: constants for the scope settings bit-field bank
package scset_pkg;

  // ----------------------------------------------------------------
  // Settings byte indices
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CH1 = 6'h01;
  localparam logic [5:0] IDX_CH2 = 6'h02;
  localparam logic [5:0] IDX_LOGIC = 6'h03;
  localparam logic [5:0] IDX_TRIG = 6'h05;
  localparam logic [5:0] IDX_CURSOR = 6'h06;
  localparam logic [5:0] IDX_DISPLAY = 6'h07;
  localparam logic [5:0] IDX_SPECTRUM = 6'h08;
  localparam logic [5:0] IDX_SWEEP = 6'h09;
  localparam logic [5:0] IDX_SNIFF = 6'h0A;
  localparam logic [5:0] IDX_STATUS = 6'h0B;
  localparam logic [5:0] IDX_ACQ_LIMIT = 6'h0E;
  localparam logic [5:0] IDX_GEN_LIMIT = 6'h22;
  localparam logic [5:0] IDX_LAST = 6'h2A;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SETTING = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [15:0] RST_BAUD_DIV = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions shared by several bytes; status bit positions and host mask
  // ----------------------------------------------------------------
  localparam int BIT_ON = 0;
  localparam int BIT_INVERT = 4;
  localparam int BIT_STOPPED = 4;
  localparam int BIT_TRIGGERED = 5;
  localparam logic [7:0] STATUS_HOST_MASK = 8'hCF;

  // ----------------------------------------------------------------
  // Clock and UART sniffer rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_0 = 1200;
  localparam int BAUD_1 = 2400;
  localparam int BAUD_2 = 4800;
  localparam int BAUD_3 = 9600;
  localparam int BAUD_4 = 19200;
  localparam int BAUD_5 = 38400;
  localparam int BAUD_6 = 57600;
  localparam int BAUD_7 = 115200;

  // Grid styles
  typedef enum logic [1:0] {
    SCSET_GRID_NONE = 2'b00,
    SCSET_GRID_DOTS = 2'b01,
    SCSET_GRID_FOLLOW = 2'b10,
    SCSET_GRID_GRATICULE = 2'b11
  } scset_grid_t;

  // Spectrum window encoding
  typedef enum logic [1:0] {
    SCSET_WIN_NONE = 2'b00,
    SCSET_WIN_HAMMING = 2'b01,
    SCSET_WIN_HANN = 2'b10,
    SCSET_WIN_BLACKMAN = 2'b11
  } scset_win_t;

endpackage : scset_pkg

// >>> sim/scset_bank_chk.sv
// Checker: port-level properties of the settings bank
`timescale 1ns/10ps
module scset_bank_chk (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic WR_EN,
  input wire logic [5:0] WR_INDEX,
  input wire logic [7:0] WR_DATA,
  input wire logic [5:0] RD_INDEX,
  input wire logic [7:0] RD_DATA,
  input wire logic GEN_RELOAD_DONE,
  input wire logic [1:0] ANA_ON,
  input wire logic TRIG_NORMAL,
  input wire logic TRIG_SINGLE,
  input wire logic TRIG_SLOPE,
  input wire logic TRIG_WINDOW,
  input wire logic TRIG_EDGE,
  input wire logic TRIG_DUAL_EDGE,
  input wire logic [1:0] GRID_STYLE,
  input wire logic UART_TWO_STOP,
  input wire logic RELOAD_GEN,
  input wire logic RELOAD_ACQ,
  input wire logic METER_VDC,
  input wire logic METER_VPP,
  input wire logic METER_FREQ
);
  // ----------------------------------------------------------------
  // Clocking and reset for every property
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // Dual edge only when no mode; skip first edge
  a_dual_edge: assert property ($past(ARST_N) |-> TRIG_DUAL_EDGE ==
    !(TRIG_SLOPE || TRIG_WINDOW || TRIG_EDGE)) else $error("dual edge");
  a_meter_freq: assert property (METER_FREQ ==
    !(METER_VDC || METER_VPP)) else $error("meter freq");
  a_single_gate: assert property (TRIG_SINGLE |-> TRIG_NORMAL)
    else $error("single without normal");
  a_acq_flag: assert property (WR_EN &&
    WR_INDEX < scset_pkg::IDX_ACQ_LIMIT |-> ##2 RELOAD_ACQ)
    else $error("acq flag missing");
  a_gen_flag: assert property (WR_EN &&
    WR_INDEX > scset_pkg::IDX_GEN_LIMIT &&
    WR_INDEX <= scset_pkg::IDX_LAST |-> ##2 RELOAD_GEN)
    else $error("gen flag missing");
  // Uncontested done clears generator flag
  a_gen_clear: assert property (GEN_RELOAD_DONE && !(WR_EN &&
    (WR_INDEX > scset_pkg::IDX_GEN_LIMIT ||
    WR_INDEX == scset_pkg::IDX_STATUS)) |-> ##2 !RELOAD_GEN)
    else $error("gen flag stuck");
  a_rd_unmapped: assert property (!(RD_INDEX inside {[6'h01:6'h03],
    [6'h05:6'h0B]}) |=> RD_DATA == 8'h00) else $error("unmapped read");
  a_ch1_on: assert property (WR_EN && WR_INDEX == scset_pkg::IDX_CH1
    |-> ##2 ANA_ON[0] == $past(WR_DATA[0], 2)) else $error("ch1 on");
  a_grid_style: assert property (WR_EN &&
    WR_INDEX == scset_pkg::IDX_DISPLAY |-> ##2
    GRID_STYLE == $past(WR_DATA[1:0], 2)) else $error("grid style");
  a_two_stop: assert property (WR_EN &&
    WR_INDEX == scset_pkg::IDX_SNIFF |-> ##2
    UART_TWO_STOP == $past(WR_DATA[7], 2)) else $error("stop bits");

  // Main scenarios reached
  c_status_wr: cover property (WR_EN && WR_INDEX == scset_pkg::IDX_STATUS);
  c_gen_done: cover property (GEN_RELOAD_DONE && RELOAD_GEN);
  c_single: cover property (TRIG_SINGLE);
endmodule : scset_bank_chk

// >>> sim/scset_bank_tb.sv
// Testbench: settings bank driven through its write and read ports
`timescale 1ns/10ps
module scset_bank_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic CLK, ARST_N, WR_EN, SCOPE_STOPPED, SCOPE_TRIGGERED;
  logic [5:0] WR_INDEX, RD_INDEX;
  logic [7:0] WR_DATA, RD_DATA, rd;
  logic [2:0] done; // Generator, acquisition, abort done pulses
  logic [1:0] ANA_ON, ANA_INVERT, ANA_AVERAGE, ANA_MATH_ON, ANA_MATH_SUB;
  logic LOGIC_ON, LOGIC_PULL_EN, LOGIC_PULL_UP, LOGIC_LOW_THICK;
  logic LOGIC_INVERT, LOGIC_SERIAL_DEC, LOGIC_PARALLEL_DEC;
  logic LOGIC_ASCII_VIEW, TRIG_NORMAL, TRIG_SINGLE, TRIG_AUTO, TRIG_SLOPE;
  logic TRIG_WINDOW, TRIG_EDGE, TRIG_DUAL_EDGE, CURSOR_H_CH1, CURSOR_H_CH2;
  logic [1:0] GRID_STYLE, FFT_WINDOW;
  logic DRAW_LINES, VIEW_SCOPE, VIEW_XY, VIEW_FFT, VIEW_METER;
  logic [3:0] SWEEP_ENABLE;
  logic SWEEP_ACCEL_DIR, SWEEP_ACCEL, SWEEP_DIR, SWEEP_PING_PONG;
  logic [15:0] UART_BAUD_DIV;
  logic SPI_CPOL, SNIFF_CLOCK_PHASE, UART_PARITY_EN, UART_PARITY_ODD;
  logic UART_TWO_STOP, ABORT_TRIG_WAIT, RELOAD_GEN, RELOAD_ACQ;
  logic SNIFF_MODE, METER_VDC, METER_VPP, METER_FREQ;
  int bad_count;
  int checks;
  logic [7:0] pat [2] = '{8'hEE, 8'h11};
  int baud [8] = '{scset_pkg::BAUD_0, scset_pkg::BAUD_1, scset_pkg::BAUD_2,
    scset_pkg::BAUD_3, scset_pkg::BAUD_4, scset_pkg::BAUD_5,
    scset_pkg::BAUD_6, scset_pkg::BAUD_7};

  // ----------------------------------------------------------------
  // Design, host and clock
  // ----------------------------------------------------------------
  scset_bank u_scset_bank (.CLK(CLK), .ARST_N(ARST_N), .WR_EN(WR_EN),
    .WR_INDEX(WR_INDEX), .WR_DATA(WR_DATA), .RD_INDEX(RD_INDEX),
    .RD_DATA(RD_DATA), .GEN_RELOAD_DONE(done[2]),
    .ACQ_RELOAD_DONE(done[1]), .TRIG_ABORT_DONE(done[0]),
    .SCOPE_STOPPED(SCOPE_STOPPED), .SCOPE_TRIGGERED(SCOPE_TRIGGERED),
    .ANA_ON(ANA_ON), .ANA_INVERT(ANA_INVERT), .ANA_AVERAGE(ANA_AVERAGE),
    .ANA_MATH_ON(ANA_MATH_ON), .ANA_MATH_SUB(ANA_MATH_SUB),
    .LOGIC_ON(LOGIC_ON), .LOGIC_PULL_EN(LOGIC_PULL_EN),
    .LOGIC_PULL_UP(LOGIC_PULL_UP), .LOGIC_LOW_THICK(LOGIC_LOW_THICK),
    .LOGIC_INVERT(LOGIC_INVERT), .LOGIC_SERIAL_DEC(LOGIC_SERIAL_DEC),
    .LOGIC_PARALLEL_DEC(LOGIC_PARALLEL_DEC),
    .LOGIC_ASCII_VIEW(LOGIC_ASCII_VIEW), .TRIG_NORMAL(TRIG_NORMAL),
    .TRIG_SINGLE(TRIG_SINGLE), .TRIG_AUTO(TRIG_AUTO),
    .TRIG_SLOPE(TRIG_SLOPE), .TRIG_WINDOW(TRIG_WINDOW),
    .TRIG_EDGE(TRIG_EDGE), .TRIG_DUAL_EDGE(TRIG_DUAL_EDGE),
    .CURSOR_H_CH1(CURSOR_H_CH1), .CURSOR_H_CH2(CURSOR_H_CH2),
    .GRID_STYLE(GRID_STYLE), .DRAW_LINES(DRAW_LINES),
    .FFT_WINDOW(FFT_WINDOW), .VIEW_SCOPE(VIEW_SCOPE), .VIEW_XY(VIEW_XY),
    .VIEW_FFT(VIEW_FFT), .VIEW_METER(VIEW_METER),
    .SWEEP_ENABLE(SWEEP_ENABLE), .SWEEP_ACCEL_DIR(SWEEP_ACCEL_DIR),
    .SWEEP_ACCEL(SWEEP_ACCEL), .SWEEP_DIR(SWEEP_DIR),
    .SWEEP_PING_PONG(SWEEP_PING_PONG), .UART_BAUD_DIV(UART_BAUD_DIV),
    .SPI_CPOL(SPI_CPOL), .SNIFF_CLOCK_PHASE(SNIFF_CLOCK_PHASE),
    .UART_PARITY_EN(UART_PARITY_EN), .UART_PARITY_ODD(UART_PARITY_ODD),
    .UART_TWO_STOP(UART_TWO_STOP), .ABORT_TRIG_WAIT(ABORT_TRIG_WAIT),
    .RELOAD_GEN(RELOAD_GEN), .RELOAD_ACQ(RELOAD_ACQ),
    .SNIFF_MODE(SNIFF_MODE), .METER_VDC(METER_VDC),
    .METER_VPP(METER_VPP), .METER_FREQ(METER_FREQ));
  scset_host u_scset_host (.clk(CLK), .wr_en(WR_EN), .wr_index(WR_INDEX),
    .wr_data(WR_DATA), .rd_index(RD_INDEX), .rd_data(RD_DATA));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic stop_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // Write, then settle
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    u_scset_host.put(idx, d);
    @(negedge CLK);
  endtask : wr
  // Read one byte and compare it
  task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
    u_scset_host.get(idx, rd);
    cmp(16'(rd), 16'(e));
  endtask : rchk
  // One-cycle done pulse, then settle
  task automatic pulse(input logic [2:0] m);
    @(negedge CLK);
    done = m;
    @(negedge CLK);
    done = 3'h0;
    @(negedge CLK);
  endtask : pulse

  // Watchdog
  initial begin
    #(4000 * 50);
    bad_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ARST_N = 1'b0;
    done = 3'h0;
    SCOPE_STOPPED = 1'b1;
    SCOPE_TRIGGERED = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (4) @(negedge CLK);
    ARST_N = 1'b1;
    @(negedge CLK);
    cmp(16'(TRIG_DUAL_EDGE), 16'h0001);
    cmp(16'(VIEW_METER), 16'h0001);
    cmp(16'(METER_FREQ), 16'h0001);
    rchk(scset_pkg::IDX_CH1, 8'h00);
    wr(scset_pkg::IDX_CH1, 8'hF1);
    wr(scset_pkg::IDX_CH2, 8'h70);
    cmp(16'({ANA_MATH_SUB, ANA_MATH_ON}), 16'h0007);
    cmp(16'({ANA_ON, ANA_INVERT, ANA_AVERAGE}), 16'h001F);
    rchk(scset_pkg::IDX_CH1, 8'hF1);
    foreach (pat[i]) begin
      wr(scset_pkg::IDX_LOGIC, pat[i]);
      cmp(16'({LOGIC_ASCII_VIEW, LOGIC_PARALLEL_DEC, LOGIC_SERIAL_DEC,
        LOGIC_INVERT, LOGIC_LOW_THICK, LOGIC_PULL_UP, LOGIC_PULL_EN,
        LOGIC_ON}), 16'(pat[i]));
      wr(scset_pkg::IDX_SWEEP, pat[i]);
      cmp(16'({SWEEP_ENABLE, SWEEP_PING_PONG, SWEEP_DIR, SWEEP_ACCEL,
        SWEEP_ACCEL_DIR}), 16'(pat[i]));
      wr(scset_pkg::IDX_SNIFF, pat[i]);
      cmp(16'({UART_TWO_STOP, UART_PARITY_ODD, UART_PARITY_EN,
        SNIFF_CLOCK_PHASE, SPI_CPOL}), 16'(pat[i][7:3]));
      wr(scset_pkg::IDX_DISPLAY, pat[i]);
      cmp(16'(DRAW_LINES), 16'(pat[i][6]));
    end
    for (int i = 0; i < 8; i++) begin
      wr(scset_pkg::IDX_SNIFF, 8'(i));
      cmp(UART_BAUD_DIV, 16'(scset_pkg::CLK_HZ / baud[i]));
      wr(scset_pkg::IDX_DISPLAY, 8'(i));
      cmp(16'(GRID_STYLE), 16'(i % 4));
    end
    // Walking mode bit; the last step clears all three
    for (int i = 0; i < 4; i++) begin
      wr(scset_pkg::IDX_TRIG, 8'(8'h20 << i));
      cmp(16'({TRIG_DUAL_EDGE, TRIG_EDGE, TRIG_WINDOW, TRIG_SLOPE}),
        16'(4'h1 << i));
      wr(scset_pkg::IDX_SPECTRUM, 8'(8'h20 << i));
      cmp(16'({VIEW_METER, VIEW_FFT, VIEW_XY, VIEW_SCOPE}),
        16'(4'h1 << i));
    end
    for (int i = 0; i < 3; i++) begin
      wr(scset_pkg::IDX_SPECTRUM, 8'(8'h01 << i));
      cmp(16'(FFT_WINDOW), 16'(i + 1));
    end
    wr(scset_pkg::IDX_TRIG, 8'h06);
    cmp(16'({TRIG_AUTO, TRIG_SINGLE, TRIG_NORMAL}), 16'h0007);
    wr(scset_pkg::IDX_CURSOR, 8'h18);
    cmp(16'({CURSOR_H_CH2, CURSOR_H_CH1}), 16'h0001);
    // Update flags by index and done
    pulse(3'h2);
    wr(scset_pkg::IDX_ACQ_LIMIT, 8'h5A);
    wr(scset_pkg::IDX_GEN_LIMIT, 8'h5A);
    cmp(16'({RELOAD_GEN, RELOAD_ACQ}), 16'h0000);
    wr(6'h23, 8'h00);
    cmp(16'({RELOAD_GEN, RELOAD_ACQ}), 16'h0002);
    pulse(3'h4);
    cmp(16'(RELOAD_GEN), 16'h0000);
    wr(6'h0D, 8'h77);
    cmp(16'({RELOAD_GEN, RELOAD_ACQ}), 16'h0001);
    rchk(6'h0D, 8'h00);
    rchk(6'h04, 8'h00);
    // Status host bits and input-fed bits
    wr(scset_pkg::IDX_STATUS, 8'hFB);
    cmp(16'({METER_FREQ, SNIFF_MODE, ABORT_TRIG_WAIT}),
      16'h0003);
    rchk(scset_pkg::IDX_STATUS, 8'hDF);
    pulse(3'h1);
    cmp(16'(ABORT_TRIG_WAIT), 16'h0000);
    SCOPE_STOPPED = 1'b0;
    SCOPE_TRIGGERED = 1'b1;
    wr(scset_pkg::IDX_STATUS, 8'h40);
    cmp(16'({METER_VPP, METER_VDC, METER_FREQ}), 16'h0002);
    rchk(scset_pkg::IDX_STATUS, 8'h64);
    stop_test();
  end
endmodule : scset_bank_tb

bind scset_bank scset_bank_chk u_scset_bank_chk (.CLK, .ARST_N, .WR_EN,
  .WR_INDEX, .WR_DATA, .RD_INDEX, .RD_DATA, .GEN_RELOAD_DONE, .ANA_ON,
  .TRIG_NORMAL, .TRIG_SINGLE, .TRIG_SLOPE, .TRIG_WINDOW, .TRIG_EDGE,
  .TRIG_DUAL_EDGE, .GRID_STYLE, .UART_TWO_STOP, .RELOAD_GEN, .RELOAD_ACQ,
  .METER_VDC, .METER_VPP, .METER_FREQ);

// >>> sim/scset_host.sv
// Host model: settings writes and reads at the falling clock edge
`timescale 1ns/10ps
module scset_host (
  input wire logic clk,
  output logic wr_en,
  output logic [5:0] wr_index,
  output logic [7:0] wr_data,
  output logic [5:0] rd_index,
  input wire logic [7:0] rd_data
);
  // Idle bus from time zero
  initial begin
    wr_en = 1'b0;
    wr_index = 6'h3F;
    wr_data = 8'h00;
    rd_index = 6'h00;
  end

  // One-cycle write; host-side rules applied
  task automatic put(input logic [5:0] idx, input logic [7:0] dat);
    logic [7:0] d;
    d = dat;
    if (idx == scset_pkg::IDX_TRIG && d[1]) begin
      d[0] = 1'b1;
    end
    if (idx == scset_pkg::IDX_CURSOR && d[3]) begin
      d[4] = 1'b0;
    end
    if (idx == scset_pkg::IDX_SPECTRUM) begin
      d[2:0] = d[2:0] & (~d[2:0] + 3'h1);
    end
    @(negedge clk);
    wr_en = 1'b1;
    wr_index = idx;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    // Released lines show the inverse
    wr_index = ~idx;
    wr_data = ~d;
  endtask : put

  // Index out, data taken next cycle
  task automatic get(input logic [5:0] idx, output logic [7:0] dat);
    @(negedge clk);
    rd_index = idx;
    @(negedge clk);
    dat = rd_data;
  endtask : get
endmodule : scset_host
